/* File: pcp_defines.vh */
`ifndef PCP_DEFINES_VH
`define PCP_DEFINES_VH

// Clock and boot_self_init power-up blocking time
`define PCP_CLK_MHZ 250
`define PCP_BLOCK_US 500
`define PCP_BLOCK_CYCLES (`PCP_BLOCK_US * `PCP_CLK_MHZ)
`define PCP_BLOCK_WIDTH 17

// Keys written to the configuration port
`define PCP_KEY_ENTER 8'h55
`define PCP_KEY_EXIT 8'haa

// Configuration port base per latched strap
`define PCP_BASE_LO_STRAP0 8'hf0
`define PCP_BASE_LO_STRAP1 8'h70
`define PCP_BASE_HI_RESET 8'h03
`define PCP_DATA_PORT_OFS 16'h0001

// Global register indices and first device register index
`define PCP_IDX_CONFIG_CONTROL 8'h02
`define PCP_IDX_INDEX_ADDRESS 8'h03
`define PCP_IDX_LD_SELECT 8'h07
`define PCP_IDX_CHIP_ID 8'h20
`define PCP_IDX_CHIP_REV 8'h21
`define PCP_IDX_POWER_CONTROL 8'h22
`define PCP_IDX_POWER_MGMT 8'h23
`define PCP_IDX_OSC_CONTROL 8'h24
`define PCP_IDX_BASE_LO 8'h26
`define PCP_IDX_BASE_HI 8'h27
`define PCP_IDX_CLOCK_MASK 8'h28
`define PCP_IDX_TEST_FOUR 8'h2b
`define PCP_IDX_TEST_FIVE 8'h2c
`define PCP_IDX_TEST_ONE 8'h2d
`define PCP_IDX_LD_FIRST 8'h30

// Field positions
`define PCP_SOFT_RESET_BIT 0

// Reset values
`define PCP_RST_CONFIG_CONTROL 8'h00
`define PCP_RST_INDEX_ADDRESS 8'h03
`define PCP_RST_LD_SELECT 8'h00
`define PCP_RST_POWER_CONTROL 8'h00
`define PCP_RST_POWER_MGMT 8'h00
`define PCP_RST_OSC_CONTROL 8'h04
`define PCP_RST_CLOCK_MASK 8'h00
`define PCP_RST_TEST 8'h00
`define PCP_RST_INDEX 8'h00

// Identification codes, values arbitrary
`define PCP_CHIP_ID_VALUE 8'h5a
`define PCP_CHIP_REV_VALUE 8'h01

`endif

/* File: pcp_blank_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defines.vh"

module pcp_blank_timer
#(
  parameter P_CYCLES = `PCP_BLOCK_CYCLES,
  parameter P_WIDTH = `PCP_BLOCK_WIDTH
)
(
  input wire i_clk,
  input wire i_rstn,
  output reg o_busy
);

  localparam integer LOAD_FULL = P_CYCLES - 1;
  localparam [P_WIDTH-1:0] LOAD = LOAD_FULL[P_WIDTH-1:0];

  reg [P_WIDTH-1:0] count;

  ////////////////////////////////////////////////////////////////////////
  // Down counter started by power-on reset
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      count <= LOAD;
      o_busy <= 1'b1;
    end
    else if (o_busy)
    begin
      if (count == {P_WIDTH{1'b0}})
      begin
        o_busy <= 1'b0;
      end
      else
      begin
        count <= count - {{(P_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pcp_blank_timer

`default_nettype wire

/* File: pcp_config_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defines.vh"

module pcp_config_port
#(
  parameter P_BLOCK_CYCLES = `PCP_BLOCK_CYCLES,
  parameter P_BLOCK_WIDTH = `PCP_BLOCK_WIDTH
)
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_host_reset,
  input wire i_strap_base_select,
  input wire i_aen,
  input wire [15:0] i_addr,
  input wire [7:0] i_data,
  input wire i_iow,
  input wire i_ior,
  input wire [7:0] i_ld_rdata,
  output reg [7:0] o_data,
  output reg o_data_oen,
  output reg o_cfg_state,
  output reg o_access_blocked,
  output reg o_ld_deactivate,
  output reg o_soft_reset,
  output reg [7:0] o_ld_select,
  output reg [7:0] o_ld_index,
  output reg [7:0] o_ld_wdata,
  output reg o_ld_wr,
  output reg o_ld_rd,
  output reg [7:0] o_power_control,
  output reg [7:0] o_power_management,
  output reg [7:0] o_oscillator_control,
  output reg [7:0] o_clock_mask
);

  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_CFG = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg strap_pending;
  reg [7:0] index;
  reg [7:0] index_address;
  reg [7:0] config_port_base_low;
  reg [7:0] config_port_base_high;
  reg [7:0] test_reg_four;
  reg [7:0] test_reg_five;
  reg [7:0] test_reg_one;
  reg [7:0] rd_value;
  wire timer_busy;
  wire [15:0] base_addr;
  wire [15:0] data_addr;
  wire [16:0] data_sum;
  wire blocked;
  wire hit_base;
  wire hit_data;
  wire in_cfg;
  wire key_write;
  wire idx_write;
  wire idx_read;
  wire dat_write;
  wire dat_read;
  wire ld_space;

  ////////////////////////////////////////////////////////////////////////
  // Power-up blocking timer
  // boot_self_init power-up block
  pcp_blank_timer
  #(
    .P_CYCLES(P_BLOCK_CYCLES),
    .P_WIDTH(P_BLOCK_WIDTH)
  )
  u_blank_timer
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_busy(timer_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  // relocatable base decode
  assign base_addr = {config_port_base_high, config_port_base_low};
  assign data_sum = {1'b0, base_addr} + {1'b0, `PCP_DATA_PORT_OFS};
  assign data_addr = data_sum[15:0];
  assign blocked = timer_busy | strap_pending | i_host_reset;
  assign hit_base = !i_aen && !blocked && (i_addr == base_addr);
  assign hit_data = !i_aen && !blocked && (i_addr == data_addr);
  assign in_cfg = (state == ST_CFG);
  assign key_write = hit_base && i_iow;
  assign idx_write = in_cfg && hit_base && i_iow;
  assign idx_read = in_cfg && hit_base && i_ior;
  assign dat_write = in_cfg && hit_data && i_iow;
  assign dat_read = in_cfg && hit_data && i_ior;
  assign ld_space = (index >= `PCP_IDX_LD_FIRST);

  ////////////////////////////////////////////////////////////////////////
  // Configuration state machine
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (key_write && (i_data == `PCP_KEY_ENTER))
        begin
          next_state = ST_CFG;
        end
      end
      ST_CFG:
      begin
        if (key_write && (i_data == `PCP_KEY_EXIT))
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data select
  always @*
  begin
    rd_value = 8'h00;
    if (idx_read)
    begin
      rd_value = index;
    end
    else if (ld_space)
    begin
      rd_value = i_ld_rdata;
    end
    else
    begin
      case (index)
        `PCP_IDX_INDEX_ADDRESS: rd_value = index_address;
        `PCP_IDX_LD_SELECT: rd_value = o_ld_select;
        `PCP_IDX_CHIP_ID: rd_value = `PCP_CHIP_ID_VALUE;
        `PCP_IDX_CHIP_REV: rd_value = `PCP_CHIP_REV_VALUE;
        `PCP_IDX_POWER_CONTROL: rd_value = o_power_control;
        `PCP_IDX_POWER_MGMT: rd_value = o_power_management;
        `PCP_IDX_OSC_CONTROL: rd_value = o_oscillator_control;
        `PCP_IDX_BASE_LO: rd_value = config_port_base_low;
        `PCP_IDX_BASE_HI: rd_value = config_port_base_high;
        `PCP_IDX_CLOCK_MASK: rd_value = o_clock_mask;
        `PCP_IDX_TEST_FOUR: rd_value = test_reg_four;
        `PCP_IDX_TEST_FIVE: rd_value = test_reg_five;
        `PCP_IDX_TEST_ONE: rd_value = test_reg_one;
        default: rd_value = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state <= ST_RUN;
      strap_pending <= 1'b1;
      index <= `PCP_RST_INDEX;
      index_address <= `PCP_RST_INDEX_ADDRESS;
      o_ld_select <= `PCP_RST_LD_SELECT;
      o_power_control <= `PCP_RST_POWER_CONTROL;
      o_power_management <= `PCP_RST_POWER_MGMT;
      o_oscillator_control <= `PCP_RST_OSC_CONTROL;
      o_clock_mask <= `PCP_RST_CLOCK_MASK;
      config_port_base_low <= `PCP_BASE_LO_STRAP0;
      config_port_base_high <= `PCP_BASE_HI_RESET;
      test_reg_four <= `PCP_RST_TEST;
      test_reg_five <= `PCP_RST_TEST;
      test_reg_one <= `PCP_RST_TEST;
      o_ld_deactivate <= 1'b1;
      o_soft_reset <= 1'b0;
      o_ld_wr <= 1'b0;
      o_ld_rd <= 1'b0;
      o_ld_index <= 8'h00;
      o_ld_wdata <= 8'h00;
      o_data <= 8'h00;
      o_data_oen <= 1'b1;
      o_cfg_state <= 1'b0;
      o_access_blocked <= 1'b1;
    end
    else if (i_host_reset)
    begin
      state <= ST_RUN;
      strap_pending <= 1'b1;
      index <= `PCP_RST_INDEX;
      o_ld_index <= `PCP_RST_INDEX;
      index_address <= `PCP_RST_INDEX_ADDRESS;
      o_ld_select <= `PCP_RST_LD_SELECT;
      o_power_control <= `PCP_RST_POWER_CONTROL;
      o_power_management <= `PCP_RST_POWER_MGMT;
      o_oscillator_control <= `PCP_RST_OSC_CONTROL;
      o_clock_mask <= `PCP_RST_CLOCK_MASK;
      o_ld_deactivate <= 1'b1;
      o_soft_reset <= 1'b0;
      o_ld_wr <= 1'b0;
      o_ld_rd <= 1'b0;
      o_data_oen <= 1'b1;
      o_cfg_state <= 1'b0;
      o_access_blocked <= 1'b1;
    end
    else
    begin
      state <= next_state;
      o_cfg_state <= (next_state == ST_CFG);
      o_access_blocked <= timer_busy;
      o_ld_deactivate <= 1'b0;
      o_soft_reset <= 1'b0;
      o_ld_wr <= 1'b0;
      o_ld_rd <= 1'b0;
      o_data <= rd_value;
      o_data_oen <= !(idx_read || dat_read);
      if (strap_pending)
      begin
        strap_pending <= 1'b0;
        config_port_base_low <= i_strap_base_select ?
          `PCP_BASE_LO_STRAP1 : `PCP_BASE_LO_STRAP0;
        config_port_base_high <= `PCP_BASE_HI_RESET;
      end
      if (idx_write && (i_data != `PCP_KEY_EXIT))
      begin
        index <= i_data;
        o_ld_index <= i_data;
      end
      if (dat_read && ld_space)
      begin
        o_ld_rd <= 1'b1;
        o_ld_index <= index;
      end
      if (dat_write)
      begin
        if (ld_space)
        begin
          o_ld_wr <= 1'b1;
          o_ld_index <= index;
          o_ld_wdata <= i_data;
        end
        else
        begin
          case (index)
            `PCP_IDX_CONFIG_CONTROL:
            begin
              if (i_data[`PCP_SOFT_RESET_BIT])
              begin
                o_soft_reset <= 1'b1;
                o_ld_select <= `PCP_RST_LD_SELECT;
                o_power_control <= `PCP_RST_POWER_CONTROL;
                o_clock_mask <= `PCP_RST_CLOCK_MASK;
              end
            end
            `PCP_IDX_INDEX_ADDRESS: index_address <= i_data;
            `PCP_IDX_LD_SELECT: o_ld_select <= i_data;
            `PCP_IDX_POWER_CONTROL: o_power_control <= i_data;
            `PCP_IDX_POWER_MGMT: o_power_management <= i_data;
            `PCP_IDX_OSC_CONTROL: o_oscillator_control <= i_data;
            `PCP_IDX_BASE_LO: config_port_base_low <= i_data;
            `PCP_IDX_BASE_HI: config_port_base_high <= i_data;
            `PCP_IDX_CLOCK_MASK: o_clock_mask <= i_data;
            `PCP_IDX_TEST_FOUR: test_reg_four <= i_data;
            `PCP_IDX_TEST_FIVE: test_reg_five <= i_data;
            `PCP_IDX_TEST_ONE: test_reg_one <= i_data;
            default:
            begin
              o_soft_reset <= 1'b0;
            end
          endcase
        end
      end
    end
  end

endmodule // pcp_config_port

`default_nettype wire

/* File: pcp_config_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pcp_config_port_props
#(
  parameter P_BLOCK_CYCLES = 125000
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_host_reset,
  input wire logic i_aen,
  input wire logic [7:0] i_data,
  input wire logic i_iow,
  input wire logic i_ior,
  input wire logic o_data_oen,
  input wire logic o_cfg_state,
  input wire logic o_access_blocked,
  input wire logic o_ld_deactivate,
  input wire logic o_soft_reset,
  input wire logic o_ld_wr
);
  int unsigned blk_run;
  // Length of the current access block
  always @(posedge i_clk)
  begin
    if (!i_rstn || !o_access_blocked || i_host_reset)
    begin
      blk_run <= 0;
    end
    else
    begin
      blk_run <= blk_run + 1;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  //////////////////////////////////////////////////////////////////////
  AST_ENTER: assert property (
    $rose(o_cfg_state) |-> $past(i_iow && !i_aen && i_data == 8'h55))
    else $error("config state entered without entry key");
  AST_EXIT: assert property (
    $fell(o_cfg_state) |-> $past(i_host_reset ||
      (i_iow && !i_aen && i_data == 8'haa)))
    else $error("config state left without exit key");
  AST_AEN: assert property (
    i_aen && i_ior |=> o_data_oen)
    else $error("read served with AEN high");
  AST_RUN_READ: assert property (
    !o_cfg_state && i_ior |=> o_data_oen)
    else $error("read served in run state");
  AST_BLOCKED: assert property (
    (o_access_blocked && i_ior) ##1 o_access_blocked |-> o_data_oen)
    else $error("read served while blocked");
  AST_BLOCK_END: assert property (
    blk_run <= P_BLOCK_CYCLES + 1)
    else $error("access block lasted too long");
  AST_HOST_RESET: assert property (
    i_host_reset |=> o_ld_deactivate && !o_cfg_state && o_data_oen)
    else $error("host reset state wrong");
  AST_SOFT: assert property (
    o_soft_reset |-> $past(i_iow && !i_aen && o_cfg_state && i_data[0]))
    else $error("soft reset without cause");
  AST_LD_WR: assert property (
    o_ld_wr |-> $past(i_iow && !i_aen && o_cfg_state))
    else $error("device write without cause");
  AST_READ_CAUSE: assert property (
    !o_data_oen |-> $past(i_ior && !i_aen && o_cfg_state))
    else $error("data driven without read");
  COV_ENTER: cover property ($rose(o_cfg_state));
  COV_LD_WR: cover property (o_ld_wr);
  COV_SOFT: cover property (o_soft_reset);
endmodule // pcp_config_port_props
bind pcp_config_port pcp_config_port_props
  #(.P_BLOCK_CYCLES(P_BLOCK_CYCLES)) u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_host_reset(i_host_reset),
  .i_aen(i_aen), .i_data(i_data), .i_iow(i_iow), .i_ior(i_ior),
  .o_data_oen(o_data_oen), .o_cfg_state(o_cfg_state),
  .o_access_blocked(o_access_blocked), .o_ld_deactivate(o_ld_deactivate),
  .o_soft_reset(o_soft_reset), .o_ld_wr(o_ld_wr));
`default_nettype wire

/* File: pcp_ld_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcp_ld_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_sel,
  input wire logic [7:0] i_idx,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [256];
  // Device register store
  assign o_rdata = mem[{i_sel[2:0], i_idx[4:0]}];
  always @(posedge i_clk)
  begin
    if (i_wr)
    begin
      mem[{i_sel[2:0], i_idx[4:0]}] <= i_wdata;
    end
  end
endmodule // pcp_ld_model
`default_nettype wire

/* File: test_pcp_config_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defines.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_pcp_config_port;
  logic clk = 0, rstn = 0, hrst = 0, strap = 0, aen = 0, iow = 0, ior = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] data = 8'h00, ldr, dout, ldsel, ldidx, ldw, pctl, pmgt, rv;
  logic [7:0] osc, cmask;
  logic oen, cfg, blk, deact, srst, ldwr, oe, ldrd, lr;
  int failures = 0, comparisons = 0;
  logic [7:0] ix [14] = '{8'h02, 8'h03, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23,
    8'h24, 8'h26, 8'h27, 8'h28, 8'h2b, 8'h2c, 8'h2d};
  logic [7:0] rs [14] = '{8'h00, 8'h03, 8'h00, `PCP_CHIP_ID_VALUE,
    `PCP_CHIP_REV_VALUE, 8'h00, 8'h00, 8'h04, 8'hf0, 8'h03, 8'h00, 8'h00,
    8'h00, 8'h00};
  always #2 clk = ~clk;
  pcp_config_port #(.P_BLOCK_CYCLES(20)) u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_host_reset(hrst),
    .i_strap_base_select(strap), .i_aen(aen), .i_addr(addr),
    .i_data(data), .i_iow(iow), .i_ior(ior), .i_ld_rdata(ldr),
    .o_data(dout), .o_data_oen(oen), .o_cfg_state(cfg),
    .o_access_blocked(blk), .o_ld_deactivate(deact), .o_soft_reset(srst),
    .o_ld_select(ldsel), .o_ld_index(ldidx), .o_ld_wdata(ldw),
    .o_ld_wr(ldwr), .o_ld_rd(ldrd), .o_power_control(pctl),
    .o_power_management(pmgt), .o_oscillator_control(osc),
    .o_clock_mask(cmask));
  pcp_ld_model u_ld (.i_clk(clk), .i_sel(ldsel), .i_idx(ldidx),
    .i_wdata(ldw), .i_wr(ldwr), .o_rdata(ldr));
  //////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    iow = 1;
    addr = a;
    data = d;
    @(negedge clk);
    iow = 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    ior = 1;
    addr = a;
    @(negedge clk);
    ior = 0;
    rv = dout;
    oe = oen;
    lr = ldrd;
  endtask
  task automatic sw(input logic [15:0] b, input logic [7:0] i, d);
    wr(b, i);
    wr(b + 16'h0001, d);
  endtask
  task automatic gr(input logic [15:0] b, input logic [7:0] i, e);
    wr(b, i);
    rd(b + 16'h0001);
    `CHK("read data", e, rv)
  endtask
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    failures++;
    finish_test;
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1;
    wr(16'h03f0, 8'h55);
    `CHK("blocked key", 1'b0, cfg)
    `CHK("block flag on", 1'b1, blk)
    repeat (25) @(negedge clk);
    `CHK("block flag off", 1'b0, blk)
    rd(16'h03f1);
    `CHK("run read", 1'b1, oe)
    wr(16'h03f0, 8'h12);
    `CHK("non key", 1'b0, cfg)
    aen = 1;
    wr(16'h03f0, 8'h55);
    aen = 0;
    `CHK("aen key", 1'b0, cfg)
    wr(16'h03f0, 8'h55);
    `CHK("enter", 1'b1, cfg)
    `CHK("devices on", 1'b0, deact)
    aen = 1;
    rd(16'h03f1);
    aen = 0;
    `CHK("aen read", 1'b1, oe)
    for (int k = 0; k < 14; k++)
      gr(16'h03f0, ix[k], rs[k]);
    sw(16'h03f0, 8'h20, 8'hff);
    gr(16'h03f0, 8'h20, `PCP_CHIP_ID_VALUE);
    sw(16'h03f0, 8'h21, 8'hff);
    gr(16'h03f0, 8'h21, `PCP_CHIP_REV_VALUE);
    sw(16'h03f0, 8'h2a, 8'hff);
    gr(16'h03f0, 8'h2a, 8'h00);
    sw(16'h03f0, 8'h22, 8'h5c);
    sw(16'h03f0, 8'h23, 8'h3c);
    sw(16'h03f0, 8'h24, 8'h06);
    sw(16'h03f0, 8'h28, 8'h11);
    `CHK("power control", 8'h5c, pctl)
    `CHK("clock mask", 8'h11, cmask)
    sw(16'h03f0, 8'h07, 8'h02);
    sw(16'h03f0, 8'h30, 8'h81);
    `CHK("device write strobe", 1'b1, ldwr)
    `CHK("device select", 8'h02, ldsel)
    `CHK("device index", 8'h30, ldidx)
    `CHK("device wdata", 8'h81, ldw)
    sw(16'h03f0, 8'h31, 8'h42);
    gr(16'h03f0, 8'h30, 8'h81);
    `CHK("device read strobe", 1'b1, lr)
    gr(16'h03f0, 8'h31, 8'h42);
    gr(16'h03f0, 8'h20, `PCP_CHIP_ID_VALUE);
    `CHK("global read strobe", 1'b0, lr)
    sw(16'h03f0, 8'h02, 8'h01);
    `CHK("soft pulse", 1'b1, srst)
    @(negedge clk);
    `CHK("soft pulse end", 1'b0, srst)
    `CHK("soft power control", 8'h00, pctl)
    `CHK("soft power mgmt", 8'h3c, pmgt)
    `CHK("soft osc", 8'h06, osc)
    `CHK("soft clock mask", 8'h00, cmask)
    `CHK("soft device select", 8'h00, ldsel)
    `CHK("soft stays cfg", 1'b1, cfg)
    sw(16'h03f0, 8'h26, 8'h50);
    gr(16'h0350, 8'h21, `PCP_CHIP_REV_VALUE);
    rd(16'h03f1);
    `CHK("old base", 1'b1, oe)
    wr(16'h0350, 8'haa);
    `CHK("exit", 1'b0, cfg)
    rd(16'h0351);
    `CHK("run data", 1'b1, oe)
    wr(16'h0350, 8'h55);
    strap = 1;
    hrst = 1;
    rd(16'h0351);
    `CHK("reset read", 1'b1, oe)
    `CHK("hard devices off", 1'b1, deact)
    `CHK("hard block flag", 1'b1, blk)
    hrst = 0;
    @(negedge clk);
    strap = 0;
    repeat (2) @(negedge clk);
    `CHK("hard run", 1'b0, cfg)
    wr(16'h0370, 8'h55);
    `CHK("strap base", 1'b1, cfg)
    gr(16'h0370, 8'h26, 8'h70);
    gr(16'h0370, 8'h27, 8'h03);
    finish_test;
  end
endmodule // test_pcp_config_port
`default_nettype wire
